/* rtl/sleep_wake_power_sequencer.sv */
`timescale 1ns/1ns
// How it works
// - low wake word used only asleep, timer enabled
// - high word used only in wide mode
// - narrow mode compares low 32 bits only
// - sleep holds dwell, then waits timer or pin
// - dwell counted on the running clock
// - dwell field bits 20:16 means 2^n cycles
// - phase one leaves after dwell and supplies good
// - phase two leaves after dwell and supplies good
// - bit 14 stops the tile clock
// - bit 9 picks analogue switcher modulation
// - bit 8 picks core switcher modulation
// - bit 5 enables the IO supply output
// - bit 4 enables the PLL regulator
// - bit 1 reads analogue switcher enable, fixed
// - bit 0 enables the core switcher
// - control bit 5 selects 64-bit compare
// - control bit 4 enables timer wake
// - control bits 2,3 enable and polarise pin wake
module sleep_wake_power_sequencer
    import power_seq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port, 32-bit accesses
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire power_seq_pkg::word_t regWrData,
    input wire logic regRdEn,
    output power_seq_pkg::word_t regRdData,
    output logic regRdValid,
    // Real-time counter, same clock
    input wire logic [63:0] rtcCount,
    // Pins and regulator feedback
    input wire logic resumePin,
    input wire logic [power_seq_pkg::NUM_SUPPLIES-1:0] supplyGood,
    // Supply controls
    output logic coreSwitcherEn,
    output logic analogSwitcherEn,
    output logic pllRegulatorEn,
    output logic ioSupplyOutputEn,
    output logic coreSwitcherPfm,
    output logic analogSwitcherPfm,
    output logic tileClockStop,
    output logic sleepClkDefault,
    output power_seq_pkg::power_state_t powerState
);
    import power_seq_pkg::*;

    typedef struct packed {
        power_state_t state;
        logic [7:0] genCtrl;
        word_t wakeLow;
        word_t wakeHigh;
        word_t cfgSleep;
        word_t cfgOne;
        word_t cfgTwo;
        logic [2:0] resumeSync;
        logic resumeLevel;
        logic [NUM_SUPPLIES-1:0] goodS1;
        logic [NUM_SUPPLIES-1:0] goodS2;
        logic [NUM_SUPPLIES-1:0] goodS3;
        logic [NUM_SUPPLIES-1:0] goodLevel;
        word_t outWord;
        logic clkDefault;
        word_t rdData;
        logic rdValid;
        logic [31:0] stateCycles;
    } seq_state_t;

    seq_state_t q;
    seq_state_t d;

    word_t curWord;
    logic [4:0] dwellExp;
    logic dwellDone;
    logic timeReached;
    logic timerWake;
    logic pinWake;
    logic wakeCond;
    logic suppliesGood;
    logic sleepSet;
    logic dwellMet;

    dwell_timer u_dwell (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .restart(d.state != q.state),
        .dwellExp(dwellExp),
        .dwellDone(dwellDone)
    );

    wake_comparator u_cmp (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .rtcCount(rtcCount),
        .wakeTime({q.wakeHigh, q.wakeLow}),
        .wideCompare(q.genCtrl[GC_WIDE_CMP_BIT]),
        .timeReached(timeReached)
    );

    assign curWord = stateWord(q.state, q.cfgSleep, q.cfgOne, q.cfgTwo);
    // Running state has no dwell of its own
    assign dwellExp = (q.state == RUNNING_STATE) ? RUNNING_DWELL
        : curWord[DWELL_MSB:DWELL_LSB];

    // Wake time takes part only asleep and with timer wake enabled
    assign timerWake = q.genCtrl[GC_TIMER_WAKE_BIT] && timeReached;
    assign pinWake = q.genCtrl[GC_PIN_WAKE_BIT]
        && (q.resumeLevel == q.genCtrl[GC_PIN_HIGH_BIT]);
    assign wakeCond = timerWake || pinWake;
    // Disabled supplies are not waited for
    assign suppliesGood =
        (supplyEnables(curWord) & ~q.goodLevel) == '0;

    // A request outside the running state is dropped
    assign sleepSet = regWrEn && (regAddr == OFS_GEN_CTRL)
        && regWrData[GC_SLEEP_REQ_BIT] && (q.state == RUNNING_STATE);

    always_comb begin
        d = q;

        // Pin inputs: three stages, accept a level once stages 2 and 3 agree
        d.resumeSync = {q.resumeSync[1:0], resumePin};
        if (q.resumeSync[1] == q.resumeSync[2]) begin
            d.resumeLevel = q.resumeSync[2];
        end
        d.goodS1 = supplyGood;
        d.goodS2 = q.goodS1;
        d.goodS3 = q.goodS2;
        for (int i = 0; i < NUM_SUPPLIES; i++) begin
            if (q.goodS2[i] == q.goodS3[i]) begin
                d.goodLevel[i] = q.goodS3[i];
            end
        end

        // Sequencer
        unique case (q.state)
            RUNNING_STATE: begin
                if (q.genCtrl[GC_SLEEP_REQ_BIT]) begin
                    d.state = SLEEP_STATE;
                end
            end
            SLEEP_STATE: begin
                if (dwellDone && wakeCond) begin
                    d.state = RESUME_PHASE_ONE;
                end
            end
            RESUME_PHASE_ONE: begin
                if (dwellDone && suppliesGood) begin
                    d.state = RESUME_PHASE_TWO;
                end
            end
            RESUME_PHASE_TWO: begin
                if (dwellDone && suppliesGood) begin
                    d.state = RUNNING_STATE;
                end
            end
        endcase

        // Register writes
        if (regWrEn) begin
            unique case (regAddr)
                OFS_GEN_CTRL: begin
                    d.genCtrl = (regWrData[7:0] & GC_RW_MASK)
                        | (q.genCtrl & ~GC_RW_MASK);
                end
                OFS_WAKE_LOW: d.wakeLow = regWrData;
                OFS_WAKE_HIGH: d.wakeHigh = regWrData;
                OFS_SLEEP_CFG: d.cfgSleep = regWrData & CFG_RW_MASK;
                OFS_PHASE_ONE_CFG: d.cfgOne = regWrData & CFG_RW_MASK;
                OFS_PHASE_TWO_CFG: d.cfgTwo = regWrData & CFG_RW_MASK;
                default: ;
            endcase
        end

        // Self-clearing sleep request: held until the sequencer leaves
        // running; a fresh set in the same cycle wins over the clear
        d.genCtrl[GC_SLEEP_REQ_BIT] = sleepSet
            || (q.genCtrl[GC_SLEEP_REQ_BIT] && (d.state == RUNNING_STATE));

        // Settings of the state being entered (or held) drive the pins
        d.outWord = stateWord(d.state, d.cfgSleep, d.cfgOne, d.cfgTwo);
        d.clkDefault = d.genCtrl[GC_SLEEP_CLK_BIT]
            && (d.state == SLEEP_STATE);

        // Register reads, answered one cycle later
        d.rdValid = regRdEn;
        if (regRdEn) begin
            unique case (regAddr)
                OFS_GEN_CTRL: d.rdData = {24'h00_0000, q.genCtrl};
                OFS_WAKE_LOW: d.rdData = q.wakeLow;
                OFS_WAKE_HIGH: d.rdData = q.wakeHigh;
                OFS_SLEEP_CFG: begin
                    d.rdData = stateWord(SLEEP_STATE, q.cfgSleep, q.cfgOne,
                        q.cfgTwo);
                end
                OFS_PHASE_ONE_CFG: begin
                    d.rdData = stateWord(RESUME_PHASE_ONE, q.cfgSleep,
                        q.cfgOne, q.cfgTwo);
                end
                OFS_PHASE_TWO_CFG: begin
                    d.rdData = stateWord(RESUME_PHASE_TWO, q.cfgSleep,
                        q.cfgOne, q.cfgTwo);
                end
                default: d.rdData = 32'h0000_0000;
            endcase
        end

        // Helper for checking the dwell length
        if (d.state != q.state) begin
            d.stateCycles = 32'h0000_0000;
        end else if (q.stateCycles != 32'hFFFF_FFFF) begin
            d.stateCycles = q.stateCycles + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.state <= RUNNING_STATE;
            q.genCtrl <= GC_RESET;
            q.wakeLow <= WAKE_TIME_RESET;
            q.wakeHigh <= WAKE_TIME_RESET;
            q.cfgSleep <= SLEEP_CFG_RESET;
            q.cfgOne <= PHASE_ONE_CFG_RESET;
            q.cfgTwo <= PHASE_TWO_CFG_RESET;
            q.outWord <= RUNNING_WORD;
        end else begin
            q <= d;
        end
    end

    assign coreSwitcherEn = q.outWord[CORE_EN_BIT];
    assign analogSwitcherEn = q.outWord[ANALOG_EN_BIT];
    assign pllRegulatorEn = q.outWord[PLL_EN_BIT];
    assign ioSupplyOutputEn = q.outWord[IO_EN_BIT];
    assign coreSwitcherPfm = q.outWord[CORE_PFM_BIT];
    assign analogSwitcherPfm = q.outWord[ANALOG_PFM_BIT];
    assign tileClockStop = q.outWord[TILE_CLK_STOP_BIT];
    assign sleepClkDefault = q.clkDefault;
    assign powerState = q.state;
    assign regRdData = q.rdData;
    assign regRdValid = q.rdValid;

    assign dwellMet = ({1'b0, q.stateCycles} + 33'h0_0000_0001)
        >= (33'h0_0000_0001 << dwellExp);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_leave_sleep;
        (q.state == SLEEP_STATE) ##1 (q.state == RESUME_PHASE_ONE);
    endsequence

    sequence s_leave_one;
        (q.state == RESUME_PHASE_ONE) ##1 (q.state == RESUME_PHASE_TWO);
    endsequence

    sequence s_leave_two;
        (q.state == RESUME_PHASE_TWO) ##1 (q.state == RUNNING_STATE);
    endsequence

    a_sleep_wake_cause: assert property (
        s_leave_sleep |-> $past(wakeCond) && $past(dwellDone))
        else $error("left sleep without a wake condition");

    a_sleep_needs_enable: assert property (
        (q.state == SLEEP_STATE) && !q.genCtrl[GC_TIMER_WAKE_BIT]
        && !q.genCtrl[GC_PIN_WAKE_BIT] && !regWrEn
        |=> q.state == SLEEP_STATE)
        else $error("woke with both wake sources disabled");

    a_phase_one_good: assert property (
        s_leave_one |-> $past(suppliesGood))
        else $error("phase one left with a supply not good");

    a_phase_two_good: assert property (
        s_leave_two |-> $past(suppliesGood))
        else $error("phase two left with a supply not good");

    a_dwell_minimum: assert property (
        (q.state != RUNNING_STATE) && (d.state != q.state) |-> dwellMet)
        else $error("state left before its dwell expired");

    a_resume_order: assert property (
        (q.state == SLEEP_STATE) |=> (q.state == SLEEP_STATE)
        || (q.state == RESUME_PHASE_ONE))
        else $error("sleep exited to the wrong state");

    a_sleep_entry: assert property (
        (q.state == RUNNING_STATE) && q.genCtrl[GC_SLEEP_REQ_BIT]
        |=> (q.state == SLEEP_STATE) && !q.genCtrl[GC_SLEEP_REQ_BIT])
        else $error("sleep request did not start the sequence");

    a_analog_fixed: assert property (
        ##1 analogSwitcherEn == ((q.state == RESUME_PHASE_TWO)
        || (q.state == RUNNING_STATE)))
        else $error("analogue switcher enable out of step");

    a_clock_gate: assert property (
        (q.state == RESUME_PHASE_ONE) && !regWrEn ##1
        (q.state == RESUME_PHASE_ONE) |-> tileClockStop
        == q.cfgOne[TILE_CLK_STOP_BIT])
        else $error("tile clock gate does not follow phase one word");

    // Outputs are registered from the next-state word, so they must always
    // match the word of the state now held; a lag here would power the
    // regulators with the previous state's settings
    a_tile_clock_follow: assert property (
        tileClockStop == curWord[TILE_CLK_STOP_BIT])
        else $error("tile clock gate differs from the state word");

    a_modulation_follow: assert property (
        {analogSwitcherPfm, coreSwitcherPfm}
        == {curWord[ANALOG_PFM_BIT], curWord[CORE_PFM_BIT]})
        else $error("switcher modulation differs from the state word");

    a_supply_follow: assert property (
        {ioSupplyOutputEn, pllRegulatorEn, coreSwitcherEn}
        == {curWord[IO_EN_BIT], curWord[PLL_EN_BIT], curWord[CORE_EN_BIT]})
        else $error("supply enables differ from the state word");

    a_pin_wakes: assert property (
        (q.state == SLEEP_STATE) && dwellDone && pinWake
        |=> q.state == RESUME_PHASE_ONE)
        else $error("pin wake condition ignored after the dwell");

    a_timer_wakes: assert property (
        (q.state == SLEEP_STATE) && dwellDone && timerWake
        |=> q.state == RESUME_PHASE_ONE)
        else $error("timer wake condition ignored after the dwell");

    a_request_clears: assert property (
        (q.state != RUNNING_STATE) |=> !q.genCtrl[GC_SLEEP_REQ_BIT])
        else $error("sleep request left pending outside running");

endmodule : sleep_wake_power_sequencer

/* rtl/power_seq_pkg.sv */
package power_seq_pkg;

    typedef logic [31:0] word_t;

    // Register offsets
    localparam logic [7:0] OFS_GEN_CTRL = 8'h00;
    localparam logic [7:0] OFS_WAKE_LOW = 8'h04;
    localparam logic [7:0] OFS_WAKE_HIGH = 8'h08;
    localparam logic [7:0] OFS_SLEEP_CFG = 8'h0C;
    localparam logic [7:0] OFS_PHASE_ONE_CFG = 8'h10;
    localparam logic [7:0] OFS_PHASE_TWO_CFG = 8'h14;

    // General control fields
    localparam int GC_LEVELS_BIT = 7;
    localparam int GC_WIDE_CMP_BIT = 5;
    localparam int GC_TIMER_WAKE_BIT = 4;
    localparam int GC_PIN_HIGH_BIT = 3;
    localparam int GC_PIN_WAKE_BIT = 2;
    localparam int GC_SLEEP_REQ_BIT = 1;
    localparam int GC_SLEEP_CLK_BIT = 0;
    localparam logic [7:0] GC_RESET = 8'h08;
    localparam logic [7:0] GC_RW_MASK = 8'hBD;

    // State word fields
    localparam int DWELL_LSB = 16;
    localparam int DWELL_MSB = 20;
    localparam int TILE_CLK_STOP_BIT = 14;
    localparam int ANALOG_PFM_BIT = 9;
    localparam int CORE_PFM_BIT = 8;
    localparam int IO_EN_BIT = 5;
    localparam int PLL_EN_BIT = 4;
    localparam int ANALOG_EN_BIT = 1;
    localparam int CORE_EN_BIT = 0;
    localparam word_t CFG_RW_MASK = 32'h001F_4331;

    // Values after reset (stored bits only, read-only bit 1 added on read of phase two only)
    localparam word_t WAKE_TIME_RESET = 32'h0000_0000;
    localparam word_t SLEEP_CFG_RESET = 32'h0010_0000;
    localparam word_t PHASE_ONE_CFG_RESET = 32'h0010_0020;
    localparam word_t PHASE_TWO_CFG_RESET = 32'h0010_0031;
    // Running-state word is fixed here; its register lives elsewhere
    localparam word_t RUNNING_WORD = 32'h0000_0033;
    localparam logic [4:0] RUNNING_DWELL = 5'h00;

    // Supply index in the good/enable vectors
    localparam int SUP_CORE = 0;
    localparam int SUP_ANALOG = 1;
    localparam int SUP_PLL = 2;
    localparam int SUP_IO = 3;
    localparam int NUM_SUPPLIES = 4;

    typedef enum logic [1:0] {
        RUNNING_STATE,
        SLEEP_STATE,
        RESUME_PHASE_ONE,
        RESUME_PHASE_TWO
    } power_state_t;

    // Effective word of a state, with the read-only analogue enable filled in
    function automatic word_t stateWord(
        input power_state_t st,
        input word_t sleepCfg,
        input word_t oneCfg,
        input word_t twoCfg
    );
        word_t w;
        w = RUNNING_WORD;
        unique case (st)
            RUNNING_STATE: w = RUNNING_WORD;
            SLEEP_STATE: w = sleepCfg & ~(32'h0000_0001 << ANALOG_EN_BIT);
            RESUME_PHASE_ONE: w = oneCfg & ~(32'h0000_0001 << ANALOG_EN_BIT);
            RESUME_PHASE_TWO: w = twoCfg | (32'h0000_0001 << ANALOG_EN_BIT);
        endcase
        return w;
    endfunction : stateWord

    function automatic logic [NUM_SUPPLIES-1:0] supplyEnables(input word_t w);
        return {w[IO_EN_BIT], w[PLL_EN_BIT], w[ANALOG_EN_BIT], w[CORE_EN_BIT]};
    endfunction : supplyEnables

endpackage : power_seq_pkg

/* rtl/dwell_timer.sv */
`timescale 1ns/1ns
module dwell_timer
    import power_seq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Control
    input wire logic restart,
    input wire logic [4:0] dwellExp,
    output logic dwellDone
);
    typedef struct packed {
        logic [31:0] count;
    } timer_state_t;

    timer_state_t q;
    timer_state_t d;

    // 33-bit compare so that an exponent of 31 cannot wrap
    assign dwellDone = ({1'b0, q.count} + 33'h0_0000_0001)
        >= (33'h0_0000_0001 << dwellExp);

    always_comb begin
        d = q;
        if (restart) begin
            d.count = 32'h0000_0000;
        end else if (!dwellDone) begin
            d.count = q.count + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_restart_clears: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        restart ##1 !restart |-> (dwellExp != 5'h00) || dwellDone)
        else $error("dwell timer did not restart from zero");

endmodule : dwell_timer

/* rtl/wake_comparator.sv */
`timescale 1ns/1ns
module wake_comparator
    import power_seq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Times
    input wire logic [63:0] rtcCount,
    input wire logic [63:0] wakeTime,
    input wire logic wideCompare,
    output logic timeReached
);
    typedef struct packed {
        logic reached;
    } cmp_state_t;

    cmp_state_t q;
    cmp_state_t d;

    assign timeReached = q.reached;

    always_comb begin
        d = q;
        if (wideCompare) begin
            d.reached = rtcCount >= wakeTime;
        end else begin
            d.reached = rtcCount[31:0] >= wakeTime[31:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_narrow_ignores_high: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !wideCompare && (rtcCount[31:0] >= wakeTime[31:0]) |=> timeReached)
        else $error("narrow compare looked at the upper word");

    a_wide_uses_high: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        wideCompare && (rtcCount < wakeTime) |=> !timeReached)
        else $error("wide compare matched too early");

endmodule : wake_comparator

/* verif/supply_model.sv */
`timescale 1ns/1ns
module supply_model
    import power_seq_pkg::*;
#(
    parameter logic [63:0] RTC_START = 64'h0000_0000_FFFF_F000
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Regulator controls and feedback
    input wire logic [NUM_SUPPLIES-1:0] supplyEn,
    input wire logic slowRamp,
    output logic [NUM_SUPPLIES-1:0] supplyGood,
    // Real-time counter
    output logic [63:0] rtcCount
);
    logic [5:0] rampCnt [NUM_SUPPLIES];

    // Start near a 32-bit wrap so wide compares finish in a short run
    always_ff @(posedge core_clk) begin
        rtcCount <= sys_rst ? RTC_START : rtcCount + 64'h1;
        for (int i = 0; i < NUM_SUPPLIES; i++) begin
            // A disabled supply never reports good
            if (sys_rst || !supplyEn[i]) begin
                rampCnt[i] <= 6'h00;
            end else if (rampCnt[i] != 6'h3F) begin
                rampCnt[i] <= rampCnt[i] + 6'h01;
            end
            supplyGood[i] <= supplyEn[i] && !sys_rst &&
                rampCnt[i] >= (slowRamp ? 6'h14 : 6'h02);
        end
    end
endmodule : supply_model

/* verif/sleep_wake_power_sequencer_tb.sv */
`timescale 1ns/1ns
module sleep_wake_power_sequencer_tb;
    import power_seq_pkg::*;
    localparam word_t SLEEP_W = 32'h0002_4301;
    localparam word_t ONE_W = 32'h0001_0220;
    localparam word_t TWO_W = 32'h0003_0131;
    logic core_clk, sys_rst, regWrEn, regRdEn, regRdValid;
    logic resumePin, slowRamp;
    logic [7:0] regAddr;
    word_t regWrData, regRdData, target;
    logic [63:0] rtcCount;
    logic [NUM_SUPPLIES-1:0] supplyGood;
    logic coreSwitcherEn, analogSwitcherEn, pllRegulatorEn, ioSupplyOutputEn;
    logic coreSwitcherPfm, analogSwitcherPfm, tileClockStop, sleepClkDefault;
    power_state_t powerState, prevState;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;

    sleep_wake_power_sequencer u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .rtcCount(rtcCount), .resumePin(resumePin), .supplyGood(supplyGood),
        .coreSwitcherEn(coreSwitcherEn), .analogSwitcherEn(analogSwitcherEn),
        .pllRegulatorEn(pllRegulatorEn), .ioSupplyOutputEn(ioSupplyOutputEn),
        .coreSwitcherPfm(coreSwitcherPfm),
        .analogSwitcherPfm(analogSwitcherPfm),
        .tileClockStop(tileClockStop), .sleepClkDefault(sleepClkDefault),
        .powerState(powerState)
    );

    supply_model u_model (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .supplyEn({ioSupplyOutputEn, pllRegulatorEn, analogSwitcherEn,
            coreSwitcherEn}),
        .slowRamp(slowRamp), .supplyGood(supplyGood), .rtcCount(rtcCount)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("Compared %0d values, %0d mismatches", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input word_t seen, input word_t exp, input string m);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                $time, m, seen, exp);
        end
    endtask : check

    // Each state may only hand over to the next one in the wake ring;
    // looked at on the falling edge, where the state output has settled
    always @(negedge core_clk) begin
        cycles <= cycles + 1;
        prevState <= powerState;
        if (!sys_rst && powerState != prevState) begin
            check({30'h0, powerState}, {30'h0, prevState + 2'h1}, "order");
        end
        if (cycles == 12000) begin
            errors++;
            test_done();
        end
    end

    task automatic regWrite(input logic [7:0] addr, input word_t data);
        regAddr = addr;
        regWrData = data;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
        // Idle edge, so a following call never re-raises the strobe at once
        @(negedge core_clk);
    endtask : regWrite

    task automatic expectReg(input logic [7:0] addr, input word_t exp);
        regAddr = addr;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        check({31'h0, regRdValid}, 32'h1, "read valid");
        check(regRdData, exp, "register value");
        @(negedge core_clk);
    endtask : expectReg

    task automatic checkOutputs(input word_t w, input logic analogOn);
        check({25'h0, tileClockStop, analogSwitcherPfm, coreSwitcherPfm,
            ioSupplyOutputEn, pllRegulatorEn, analogSwitcherEn,
            coreSwitcherEn}, {25'h0, w[14], w[9], w[8], w[5], w[4],
            analogOn, w[0]}, "supply outputs");
    endtask : checkOutputs

    // Waits for a state, checks its outputs, returns cycles spent in it
    task automatic stayIn(input power_state_t st, input word_t w,
        output int len);
        int guard;
        guard = 0;
        len = 0;
        while (powerState !== st && guard < 6000) begin
            @(negedge core_clk);
            guard++;
        end
        checkOutputs(w, st == RESUME_PHASE_TWO);
        while (powerState === st && len < 6000) begin
            @(negedge core_clk);
            len++;
        end
    endtask : stayIn

    task automatic runWake(input int slowMin);
        int len;
        stayIn(RESUME_PHASE_ONE, ONE_W, len);
        check({31'h0, len >= 2 && len >= slowMin}, 32'h1, "one dwell");
        stayIn(RESUME_PHASE_TWO, TWO_W, len);
        check({31'h0, len >= 8}, 32'h1, "two dwell");
        check({30'h0, powerState}, {30'h0, RUNNING_STATE}, "running");
        checkOutputs(32'h0000_0033, 1'b1);
    endtask : runWake

    initial begin
        sys_rst = 1'b1;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 32'h0000_0000;
        regRdEn = 1'b0;
        resumePin = 1'b1;
        slowRamp = 1'b0;
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        expectReg(OFS_GEN_CTRL, 32'h0000_0008);
        expectReg(OFS_WAKE_LOW, 32'h0000_0000);
        expectReg(OFS_WAKE_HIGH, 32'h0000_0000);
        expectReg(OFS_SLEEP_CFG, 32'h0010_0000);
        expectReg(OFS_PHASE_ONE_CFG, 32'h0010_0020);
        expectReg(OFS_PHASE_TWO_CFG, 32'h0010_0033);
        expectReg(8'h40, 32'h0000_0000);
        $display("test reset values done");
        // Read-only and reserved bits must not take the ones
        for (int i = 0; i < 5; i++) begin
            regWrite(8'h04 + 8'(4 * i), 32'hFFFF_FFFF);
            expectReg(8'h04 + 8'(4 * i), i < 2 ? 32'hFFFF_FFFF :
                32'h001F_4331 | (i == 4 ? 32'h2 : 32'h0));
        end
        $display("test register access done");
        regWrite(OFS_SLEEP_CFG, SLEEP_W);
        regWrite(OFS_PHASE_ONE_CFG, ONE_W);
        regWrite(OFS_PHASE_TWO_CFG, TWO_W);
        regWrite(OFS_GEN_CTRL, 32'h0000_0006);
        checkOutputs(SLEEP_W, 1'b0);
        check({31'h0, sleepClkDefault}, 32'h0, "clock select off");
        repeat (20) @(negedge core_clk);
        check({30'h0, powerState}, {30'h0, SLEEP_STATE}, "asleep");
        resumePin = 1'b0;
        stayIn(SLEEP_STATE, SLEEP_W, n);
        check({31'h0, n <= 8}, 32'h1, "pin wake");
        runWake(0);
        $display("test pin wake done");
        regWrite(OFS_WAKE_LOW, 32'h0000_0010);
        regWrite(OFS_WAKE_HIGH, 32'h0000_0001);
        slowRamp = 1'b1;
        regWrite(OFS_GEN_CTRL, 32'h0000_0032);
        stayIn(SLEEP_STATE, SLEEP_W, n);
        check({31'h0, rtcCount >= 64'h1_0000_0010 &&
            rtcCount <= 64'h1_0000_0018}, 32'h1, "wide wake");
        runWake(20);
        $display("test wide timer wake done");
        slowRamp = 1'b0;
        regWrite(OFS_WAKE_HIGH, 32'hFFFF_FFFF);
        target = rtcCount[31:0] + 32'h0000_0040;
        regWrite(OFS_WAKE_LOW, target);
        regWrite(OFS_GEN_CTRL, 32'h0000_0012);
        stayIn(SLEEP_STATE, SLEEP_W, n);
        check({31'h0, rtcCount[31:0] >= target &&
            rtcCount[31:0] <= target + 32'h8}, 32'h1, "narrow wake");
        runWake(0);
        $display("test narrow timer wake done");
        resumePin = 1'b1;
        regWrite(OFS_GEN_CTRL, 32'h0000_000F);
        check({31'h0, sleepClkDefault}, 32'h1, "clock select asleep");
        stayIn(SLEEP_STATE, SLEEP_W, n);
        check({31'h0, n >= 4}, 32'h1, "sleep dwell");
        runWake(0);
        check({31'h0, sleepClkDefault}, 32'h0, "clock select running_state");
        expectReg(OFS_GEN_CTRL, 32'h0000_000D);
        $display("test sleep dwell done");
        test_done();
    end
endmodule : sleep_wake_power_sequencer_tb
